// ### rtl/dtc_pin_sync.sv
// three-stage synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/100ps
module dtc_pin_sync (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic pin_in,
    output logic level_out,
    output logic fall_out
);

    logic stage_a;
    logic stage_b;
    logic stage_c;

    // stage_a feeds stage_b only; a change counts once b and c agree
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage_a <= 1'b1;
            stage_b <= 1'b1;
            stage_c <= 1'b1;
            level_out <= 1'b1;
            fall_out <= 1'b0;
        end else begin
            stage_a <= pin_in;
            stage_b <= stage_a;
            stage_c <= stage_b;
            if (stage_b == stage_c) begin
                level_out <= stage_c;
            end
            fall_out <= level_out && (stage_b == stage_c) && !stage_c;
        end
    end

    a_fall_one_cycle : assert property (@(posedge clk_in) disable iff (rst_in)
        fall_out |=> !fall_out && !level_out)
        else $error("falling pulse longer than one cycle");

endmodule : dtc_pin_sync

// ### rtl/dtc_tick_divider.sv
// divides the system clock into timer ticks, by slow or fast ratio
`timescale 1ns/100ps
module dtc_tick_divider #(
    parameter int SLOW_DIV = dtc_pkg::TICK_DIV_SLOW,
    parameter int FAST_DIV = dtc_pkg::TICK_DIV_FAST
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic fast_in,
    output logic tick_out
);

    localparam logic [3:0] SLOW_LAST = 4'(SLOW_DIV - 1);
    localparam logic [3:0] FAST_LAST = 4'(FAST_DIV - 1);

    logic [3:0] phase;
    logic [3:0] last;

    // wrap on >= so a switch to fast never strands the count above its limit
    assign last = fast_in ? FAST_LAST : SLOW_LAST;

    // free-running phase; affects tick rate only, never anything else
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase <= 4'h0;
            tick_out <= 1'b0;
        end else begin
            phase <= (phase >= last) ? 4'h0 : phase + 4'h1;
            tick_out <= (phase == last);
        end
    end

    a_tick_slow_rate : assert property (@(posedge clk_in) disable iff (rst_in)
        (tick_out && !fast_in ##1 !fast_in[*8] ##1 !fast_in[*3]) |=> tick_out)
        else $error("slow tick period is not twelve clocks");

    a_tick_fast_rate : assert property (@(posedge clk_in) disable iff (rst_in)
        (tick_out && fast_in ##1 fast_in[*3]) |=> tick_out)
        else $error("fast tick period is not four clocks");

endmodule : dtc_tick_divider

// ### rtl/dtc_timer_pair.sv
// two 16-bit timer/counters with mode, run and tick-divide registers
`timescale 1ns/100ps
module dtc_timer_pair (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic count_pin_zero_in,
    input wire logic count_pin_one_in,
    input wire logic qualify_pin_zero_in,
    input wire logic qualify_pin_one_in,
    input wire logic vector_ack_zero_in,
    input wire logic vector_ack_one_in,
    input wire logic timer_two_special_in,
    output logic [7:0] sfr_rdata_out,
    output logic overflow_flag_zero_out,
    output logic overflow_flag_one_out,
    output logic timer_two_tick_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dtc_pkg::dtc_count_t count_zero, count_one;
    dtc_pkg::dtc_ctl_t ctl_zero, ctl_one;
    logic run_timer_zero, run_timer_one;
    logic overflow_flag_zero, overflow_flag_one;
    logic tick_divide_select_zero, tick_divide_select_one, tick_divide_select_two;
    logic [2:0] stretch;

    logic tick_zero, tick_one, qual_zero_level, qual_one_level;
    logic count_zero_fall, count_one_fall;

    // ------------------------------------------------------------
    // count step shared by both timers
    // ------------------------------------------------------------
    function automatic dtc_pkg::dtc_step_t count_step(input dtc_pkg::dtc_mode_t mode,
                                                      input dtc_pkg::dtc_count_t cur);
        dtc_pkg::dtc_step_t res;
        res.count = cur;
        res.overflow = 1'b0;
        case (mode)
            dtc_pkg::DTC_MODE_PRESCALE: begin
                // low five bits prescale; upper three bits of low byte stay put
                res.count.low[4:0] = cur.low[4:0] + 5'h01;
                if (cur.low[4:0] == 5'h1F) begin
                    res.count.high = cur.high + 8'h01;
                    res.overflow = (cur.high == 8'hFF);
                end
            end
            dtc_pkg::DTC_MODE_FULL: begin
                res.count = dtc_pkg::dtc_count_t'(cur + 16'h0001);
                res.overflow = (cur == 16'hFFFF);
            end
            dtc_pkg::DTC_MODE_RELOAD: begin
                if (cur.low == 8'hFF) begin
                    res.count.low = cur.high;
                    res.overflow = 1'b1;
                end else begin
                    res.count.low = cur.low + 8'h01;
                end
            end
            default: res.count = cur;
        endcase
        return res;
    endfunction : count_step

    // ------------------------------------------------------------
    // tick dividers and pin conditioning
    // ------------------------------------------------------------
    dtc_tick_divider u_div_zero (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .fast_in(tick_divide_select_zero),
        .tick_out(tick_zero)
    );
    dtc_tick_divider u_div_one (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .fast_in(tick_divide_select_one),
        .tick_out(tick_one)
    );

    // special modes of timer two run from their own source, so the select is moot there
    dtc_tick_divider u_div_two (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .fast_in(tick_divide_select_two && !timer_two_special_in),
        .tick_out(timer_two_tick_out)
    );

    dtc_pin_sync u_sync_count_zero (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(count_pin_zero_in),
        .level_out(),
        .fall_out(count_zero_fall)
    );
    dtc_pin_sync u_sync_count_one (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(count_pin_one_in),
        .level_out(),
        .fall_out(count_one_fall)
    );
    dtc_pin_sync u_sync_qual_zero (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(qualify_pin_zero_in),
        .level_out(qual_zero_level),
        .fall_out()
    );
    dtc_pin_sync u_sync_qual_one (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(qualify_pin_one_in),
        .level_out(qual_one_level),
        .fall_out()
    );

    // ------------------------------------------------------------
    // decode and advance conditions
    // ------------------------------------------------------------
    logic wr_run_flag, wr_mode, wr_divide, wr_count_zero, wr_count_one;
    logic wr_low_zero, wr_high_zero, wr_low_one, wr_high_one;
    logic adv_zero, adv_one;
    dtc_pkg::dtc_step_t step_zero, step_one;

    // address decode of the special-function write strobe
    assign wr_run_flag = sfr_wr_in && (sfr_addr_in == dtc_pkg::ADDR_RUN_FLAG);
    assign wr_mode = sfr_wr_in && (sfr_addr_in == dtc_pkg::ADDR_MODE);
    assign wr_divide = sfr_wr_in && (sfr_addr_in == dtc_pkg::ADDR_DIVIDE);
    assign wr_low_zero = sfr_wr_in && (sfr_addr_in == dtc_pkg::ADDR_LOW_ZERO);
    assign wr_high_zero = sfr_wr_in && (sfr_addr_in == dtc_pkg::ADDR_HIGH_ZERO);
    assign wr_low_one = sfr_wr_in && (sfr_addr_in == dtc_pkg::ADDR_LOW_ONE);
    assign wr_high_one = sfr_wr_in && (sfr_addr_in == dtc_pkg::ADDR_HIGH_ONE);
    assign wr_count_zero = wr_low_zero || wr_high_zero;
    assign wr_count_one = wr_low_one || wr_high_one;

    // run bit, optional pin qualify, then tick or pin pulse
    assign adv_zero = run_timer_zero
        && (!ctl_zero.qualify || qual_zero_level)
        && (ctl_zero.source ? count_zero_fall : tick_zero);
    assign adv_one = run_timer_one
        && (!ctl_one.qualify || qual_one_level)
        && (ctl_one.source ? count_one_fall : tick_one);
    assign step_zero = count_step(ctl_zero.mode, count_zero);
    assign step_one = count_step(ctl_one.mode, count_one);

    // ------------------------------------------------------------
    // count registers; a software write wins over a same-cycle advance for the byte it writes, the other byte still advances
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_zero <= {dtc_pkg::COUNT_RESET, dtc_pkg::COUNT_RESET};
        end else begin
            if (adv_zero) begin
                count_zero <= step_zero.count;
            end
            if (wr_low_zero) begin
                count_zero.low <= sfr_wdata_in;
            end
            if (wr_high_zero) begin
                count_zero.high <= sfr_wdata_in;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_one <= {dtc_pkg::COUNT_RESET, dtc_pkg::COUNT_RESET};
        end else begin
            if (adv_one) begin
                count_one <= step_one.count;
            end
            if (wr_low_one) begin
                count_one.low <= sfr_wdata_in;
            end
            if (wr_high_one) begin
                count_one.high <= sfr_wdata_in;
            end
        end
    end

    // ------------------------------------------------------------
    // run and overflow flags; a new overflow wins over any clear
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            run_timer_zero <= dtc_pkg::RUN_FLAG_RESET[dtc_pkg::RUN_ZERO_POS];
            run_timer_one <= dtc_pkg::RUN_FLAG_RESET[dtc_pkg::RUN_ONE_POS];
        end else if (wr_run_flag) begin
            run_timer_zero <= sfr_wdata_in[dtc_pkg::RUN_ZERO_POS];
            run_timer_one <= sfr_wdata_in[dtc_pkg::RUN_ONE_POS];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            overflow_flag_zero <= dtc_pkg::RUN_FLAG_RESET[dtc_pkg::OVF_ZERO_POS];
            overflow_flag_one <= dtc_pkg::RUN_FLAG_RESET[dtc_pkg::OVF_ONE_POS];
        end else begin
            if (adv_zero && step_zero.overflow) begin
                overflow_flag_zero <= 1'b1;
            end else if (wr_run_flag) begin
                overflow_flag_zero <= sfr_wdata_in[dtc_pkg::OVF_ZERO_POS];
            end else if (vector_ack_zero_in) begin
                overflow_flag_zero <= 1'b0;
            end
            if (adv_one && step_one.overflow) begin
                overflow_flag_one <= 1'b1;
            end else if (wr_run_flag) begin
                overflow_flag_one <= sfr_wdata_in[dtc_pkg::OVF_ONE_POS];
            end else if (vector_ack_one_in) begin
                overflow_flag_one <= 1'b0;
            end
        end
    end

    assign overflow_flag_zero_out = overflow_flag_zero;
    assign overflow_flag_one_out = overflow_flag_one;

    // ------------------------------------------------------------
    // mode and tick-divide control
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctl_zero <= dtc_pkg::MODE_RESET[dtc_pkg::MODE_ZERO_LSB +: 4];
            ctl_one <= dtc_pkg::MODE_RESET[dtc_pkg::MODE_ONE_LSB +: 4];
        end else if (wr_mode) begin
            ctl_zero <= sfr_wdata_in[dtc_pkg::MODE_ZERO_LSB +: 4];
            ctl_one <= sfr_wdata_in[dtc_pkg::MODE_ONE_LSB +: 4];
        end
    end

    // stretch field is only held for read-back; it reaches nothing here
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_divide_select_zero <= dtc_pkg::DIVIDE_RESET[dtc_pkg::SEL_ZERO_POS];
            tick_divide_select_one <= dtc_pkg::DIVIDE_RESET[dtc_pkg::SEL_ONE_POS];
            tick_divide_select_two <= dtc_pkg::DIVIDE_RESET[dtc_pkg::SEL_TWO_POS];
            stretch <= dtc_pkg::DIVIDE_RESET[dtc_pkg::STRETCH_LSB +: 3];
        end else if (wr_divide) begin
            tick_divide_select_zero <= sfr_wdata_in[dtc_pkg::SEL_ZERO_POS];
            tick_divide_select_one <= sfr_wdata_in[dtc_pkg::SEL_ONE_POS];
            tick_divide_select_two <= sfr_wdata_in[dtc_pkg::SEL_TWO_POS];
            stretch <= sfr_wdata_in[dtc_pkg::STRETCH_LSB +: 3];
        end
    end

    // ------------------------------------------------------------
    // registered read-back, one cycle after the address; unmapped reads 00
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sfr_rdata_out <= 8'h00;
        end else begin
            case (sfr_addr_in)
                dtc_pkg::ADDR_RUN_FLAG: sfr_rdata_out <= {overflow_flag_one, run_timer_one,
                    overflow_flag_zero, run_timer_zero, 4'h0};
                dtc_pkg::ADDR_MODE: sfr_rdata_out <= {ctl_one, ctl_zero};
                dtc_pkg::ADDR_LOW_ZERO: sfr_rdata_out <= count_zero.low;
                dtc_pkg::ADDR_HIGH_ZERO: sfr_rdata_out <= count_zero.high;
                dtc_pkg::ADDR_LOW_ONE: sfr_rdata_out <= count_one.low;
                dtc_pkg::ADDR_HIGH_ONE: sfr_rdata_out <= count_one.high;
                dtc_pkg::ADDR_DIVIDE: sfr_rdata_out <= {2'h0, tick_divide_select_two,
                    tick_divide_select_one, tick_divide_select_zero, stretch};
                default: sfr_rdata_out <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_halt_mode_one : assert property (@(posedge clk_in) disable iff (rst_in)
        (ctl_one.mode == dtc_pkg::DTC_MODE_HALT && !wr_count_one) |=> $stable(count_one))
        else $error("timer one moved in halt mode");
    a_run_off_zero : assert property (@(posedge clk_in) disable iff (rst_in)
        (!run_timer_zero && !wr_count_zero) |=> $stable(count_zero))
        else $error("timer zero moved while not running");
    a_gate_block_zero : assert property (@(posedge clk_in) disable iff (rst_in)
        (ctl_zero.qualify && !qual_zero_level && !wr_count_zero) |=> $stable(count_zero))
        else $error("timer zero moved with qualify pin low");
    a_pin_source_one : assert property (@(posedge clk_in) disable iff (rst_in)
        (ctl_one.source && !count_one_fall && !wr_count_one) |=> $stable(count_one))
        else $error("timer one moved without a pin pulse");
    a_reload_low_zero : assert property (@(posedge clk_in) disable iff (rst_in)
        (adv_zero && ctl_zero.mode == dtc_pkg::DTC_MODE_RELOAD && count_zero.low == 8'hFF
            && !wr_count_zero)
        |=> (count_zero.low == $past(count_zero.high)) && overflow_flag_zero)
        else $error("reload did not copy high byte and flag");
    a_prescale_carry : assert property (@(posedge clk_in) disable iff (rst_in)
        (adv_one && ctl_one.mode == dtc_pkg::DTC_MODE_PRESCALE && count_one.low[4:0] == 5'h1F
            && !wr_count_one)
        |=> (count_one.high == $past(count_one.high) + 8'h01) && (count_one.low[4:0] == 5'h00))
        else $error("prescaler carry did not reach high byte");
    a_full_wrap_zero : assert property (@(posedge clk_in) disable iff (rst_in)
        (adv_zero && ctl_zero.mode == dtc_pkg::DTC_MODE_FULL && count_zero == 16'hFFFF
            && !wr_count_zero)
        |=> (count_zero == 16'h0000) && overflow_flag_zero_out)
        else $error("full count wrap wrong");
    a_flag_ack_clear : assert property (@(posedge clk_in) disable iff (rst_in)
        (vector_ack_one_in && !wr_run_flag && !(adv_one && step_one.overflow))
        |=> !overflow_flag_one_out)
        else $error("vector acknowledge did not clear flag");
    a_flag_set_wins : assert property (@(posedge clk_in) disable iff (rst_in)
        (adv_zero && step_zero.overflow) |=> overflow_flag_zero_out)
        else $error("overflow lost against a clear");
    a_write_low_one : assert property (@(posedge clk_in) disable iff (rst_in)
        wr_low_one |=> ##1 ($past(sfr_addr_in) != dtc_pkg::ADDR_LOW_ONE
            || sfr_rdata_out == $past(sfr_wdata_in, 2)))
        else $error("timer one low byte write lost");

endmodule : dtc_timer_pair

// ### shared/dtc_pkg.sv
// shared constants and types for the dual timer/counter block
package dtc_pkg;

    // ------------------------------------------------------------
    // register locations in the special-function space
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RUN_FLAG = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_LOW_ZERO = 8'h8A;
    localparam logic [7:0] ADDR_LOW_ONE = 8'h8B;
    localparam logic [7:0] ADDR_HIGH_ZERO = 8'h8C;
    localparam logic [7:0] ADDR_HIGH_ONE = 8'h8D;
    localparam logic [7:0] ADDR_DIVIDE = 8'h8E;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int OVF_ONE_POS = 7;
    localparam int RUN_ONE_POS = 6;
    localparam int OVF_ZERO_POS = 5;
    localparam int RUN_ZERO_POS = 4;
    localparam int MODE_ONE_LSB = 4;
    localparam int MODE_ZERO_LSB = 0;
    localparam int SEL_TWO_POS = 5;
    localparam int SEL_ONE_POS = 4;
    localparam int SEL_ZERO_POS = 3;
    localparam int STRETCH_LSB = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] RUN_FLAG_RESET = 8'h00;
    localparam logic [7:0] DIVIDE_RESET = 8'h01;

    // ------------------------------------------------------------
    // tick division in system clocks
    // ------------------------------------------------------------
    localparam int TICK_DIV_SLOW = 12;
    localparam int TICK_DIV_FAST = 4;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DTC_MODE_PRESCALE = 2'h0,
        DTC_MODE_FULL = 2'h1,
        DTC_MODE_RELOAD = 2'h2,
        DTC_MODE_HALT = 2'h3
    } dtc_mode_t;

    // one nibble of the mode control register
    typedef struct packed {
        logic qualify;
        logic source;
        dtc_mode_t mode;
    } dtc_ctl_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } dtc_count_t;

    typedef struct packed {
        dtc_count_t count;
        logic overflow;
    } dtc_step_t;

endpackage : dtc_pkg

// ### sim/dtc_pin_model.sv
// partner model: count pins and qualify pins of the two timers
`timescale 1ns/100ps
module dtc_pin_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [1:0] pulse_in,
    input wire logic [1:0] gate_in,
    output logic [1:0] count_pin_out,
    output logic [1:0] qualify_pin_out
);
    logic [2:0] low_cnt [2];
    // a pulse holds the pin low three clocks, long enough for the filter
    always_ff @(posedge clk_in or posedge rst_in) begin
        for (int i = 0; i < 2; i++) begin
            if (rst_in) low_cnt[i] <= 3'h0;
            else if (pulse_in[i]) low_cnt[i] <= 3'h3;
            else if (low_cnt[i] != 3'h0) low_cnt[i] <= low_cnt[i] - 3'h1;
        end
    end
    assign count_pin_out = {low_cnt[1] == 3'h0, low_cnt[0] == 3'h0};
    assign qualify_pin_out = gate_in;
endmodule : dtc_pin_model

// ### sim/tb.sv
// self-checking bench for the dual timer pair
`timescale 1ns/100ps
module tb;
    logic clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, sp = 1'b0, f0, f1, t2;
    logic [7:0] addr = 8'h00, wd = 8'h00, rd, lf = 8'h16, d;
    logic [7:0] v [4];
    logic [1:0] pls = 2'h0, gate = 2'h3, ack = 2'h0, cp, qp;
    int failures = 0, tests_run = 0, n;
    dtc_timer_pair uut (.clk_in(clk_in), .rst_in(rst_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
        .sfr_wdata_in(wd), .count_pin_zero_in(cp[0]), .count_pin_one_in(cp[1]),
        .qualify_pin_zero_in(qp[0]), .qualify_pin_one_in(qp[1]), .vector_ack_zero_in(ack[0]),
        .vector_ack_one_in(ack[1]), .timer_two_special_in(sp), .sfr_rdata_out(rd),
        .overflow_flag_zero_out(f0), .overflow_flag_one_out(f1), .timer_two_tick_out(t2));
    dtc_pin_model pm (.clk_in(clk_in), .rst_in(rst_in), .pulse_in(pls), .gate_in(gate),
        .count_pin_out(cp), .qualify_pin_out(qp));
    initial forever #10 clk_in = ~clk_in;
    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nx
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_in);
    endtask : cyc
    // one-cycle write strobe, then an idle cycle so two strobes never abut
    task automatic w(input logic [7:0] a, input logic [7:0] dat);
        addr = a;
        wd = dat;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        cyc(1);
    endtask : w
    // read data is registered, so it is taken one edge later
    task automatic r(input logic [7:0] a);
        addr = a;
        cyc(1);
        d = rd;
    endtask : r
    // bounded wait for an overflow flag; a hang ends the run
    task automatic wf(input int i);
        n = 0;
        while ((i ? f1 : f0) !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
        end
        if (n == 3000) begin
            failures++;
            final_report();
        end
    endtask : wf
    // wrap from ffff, then stop half a tick after the k-th tick
    task automatic rate(input int i, input int fast, input int k);
        int p;
        p = fast ? 4 : 12;
        w(8'h8E, fast ? (i ? 8'h11 : 8'h09) : 8'h01);
        w(8'h89, 8'h11);
        w(8'h8A + 8'(i), 8'hFF);
        w(8'h8C + 8'(i), 8'hFF);
        w(8'h88, i ? 8'h40 : 8'h10);
        wf(i);
        cyc(p * k + p / 2 - 1);
        w(8'h88, 8'h00);
        check(i ? f1 : f0, 1'b0);
        cyc(20);
        r(8'h8A + 8'(i));
        check(d, k);
    endtask : rate
    // 8-bit modes: wrap one tick from overflow, then vector clears flag
    task automatic ovf(input int i, input logic [7:0] m, input logic [7:0] hi,
        input logic [7:0] elo, input logic [7:0] ehi);
        w(8'h8E, 8'h01);
        w(8'h89, m);
        w(8'h8A + 8'(i), 8'hFF);
        w(8'h8C + 8'(i), hi);
        w(8'h88, i ? 8'h40 : 8'h10);
        wf(i);
        r(8'h8A + 8'(i));
        check(d, elo);
        r(8'h8C + 8'(i));
        check(d, ehi);
        ack[i] = 1'b1;
        cyc(1);
        ack = 2'h0;
        check(i ? f1 : f0, 1'b0);
        w(8'h88, 8'h00);
    endtask : ovf
    task automatic pulses(input int i, input int k);
        repeat (k) begin
            pls[i] = 1'b1;
            cyc(1);
            pls = 2'h0;
            cyc(10);
        end
    endtask : pulses
    initial begin
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        for (int a = 8'h88; a < 8'h90; a++) begin
            r(8'(a));
            check(d, a == 8'h8E ? 8'h01 : 8'h00);
        end
        for (int a = 0; a < 4; a++) begin
            lf = nx(lf);
            v[a] = lf;
            w(8'h8A + 8'(a), lf);
        end
        w(8'h89, 8'h33);
        w(8'h88, 8'h50);
        cyc(60);
        for (int a = 0; a < 4; a++) begin
            r(8'h8A + 8'(a));
            check(d, v[a]);
        end
        w(8'h88, 8'h00); // stop both, so loading ffff cannot wrap early
        $display("test registers and halt done");
        for (int i = 0; i < 4; i++) rate(i % 2, i / 2, 5);
        $display("test tick rates done");
        for (int i = 0; i < 2; i++) begin
            lf = nx(lf);
            ovf(i, 8'h00, 8'hFF, 8'hE0, 8'h00);
            ovf(i, 8'h22, lf, lf, lf);
        end
        $display("test eight-bit modes done");
        w(8'h89, 8'hDD);
        for (int i = 0; i < 2; i++) begin
            w(8'h8A + 8'(i), 8'h00);
            gate[i] = 1'b0;
            w(8'h88, i ? 8'h40 : 8'h10);
            cyc(10);
            pulses(i, 2);
            gate[i] = 1'b1;
            cyc(10);
            pulses(i, 3);
            r(8'h8A + 8'(i));
            check(d, 8'h03);
        end
        $display("test pins done");
        for (int j = 0; j < 3; j++) begin
            w(8'h8E, j < 2 ? 8'h21 : 8'h01);
            sp = (j == 1);
            cyc(12); // let the divider settle after a select change
            n = 0;
            repeat (120) begin
                cyc(1);
                n += t2;
            end
            check(n, j == 0 ? 30 : 10);
        end
        $display("test timer two tick done");
        final_report();
    end
endmodule : tb
